// ==== verilog/usb_slave_ctrl_status_regs.sv ====
// control and status register group of a usb slave controller with 8-bit host port
// Notes on behaviour
// - device address register is zero after power-up and reset.
// - after addressing, only transactions to the held address are accepted.
// - status read gives pending flags; writing one clears, zero leaves.
// - status bit 7 shows dma in progress and never raises an interrupt.
// - flags: 6 bus reset, 5 sof, 4 dma done, 3..0 endpoint done.
// - interrupt request output is active high.
// - interrupt reflects only enabled flags; enables never alter flags.
// - buffer set register bits 3..0 give set a or b; 7..4 reserved.
// - role register bit 7: one is master, zero is slave only while the role pin is one.
// - role register bit 6 swaps d+ and d- polarity; 5..0 reserved.
// - frame low holds seven frame bits in 7..1, updated on each sof.
// - frame high holds four frame bits in 7..4, updated on each sof.
// - dma total count is sixteen bits across low and high bytes.
// - writing dma count high starts dma when dma enable is set, the role pin is one and the count is not zero.
// - endpoint three is served only through dma.
// - control one bit 1 enables dma, bit 2 selects read direction.
// - select low loads write-only pointer; high accesses the register.
// - register accesses happen only with chip select and a strobe both low.
// - slave dma handshake uses request out and acknowledge in, low active.
// - active-low reset pin places the block in reset.
// - role pin zero selects host, one selects slave unless role register bit 7 is set.
// - clock multiply pin one enables the four-times multiplier.
module usb_slave_ctrl_status_regs
  import usb_slave_regs_pkg::*;
(
  // clock and resets
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       reset_in_n,
  // configuration pins
  input  wire logic       role_select,
  input  wire logic       clock_multiply_sel,
  // processor port
  input  wire logic       chip_select_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       pointer_data_select,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n,
  output logic            irq_out,
  // dma handshake
  output logic            dma_req_n,
  input  wire logic       dma_ack_n,
  // usb engine side
  input  wire usb_evt_t   usb_evt,
  input  wire usb_token_t usb_token,
  input  wire logic [FRAME_BITS-1:0] sof_frame,
  input  wire logic [NUM_ENDPOINTS-1:0] ep_buffer_set,
  input  wire logic [7:0] ep3_rd_data,
  // outputs to the usb engine
  output logic            addr_match,
  output logic            usb_enable,
  output logic            host_mode,
  output logic            polarity_swap,
  output logic            pll_enable,
  output logic            ep3_dma_stb,
  output logic            ep3_dma_write,
  output logic      [7:0] ep3_dma_data
);

  logic       reset_all;
  logic       cpu_rd_q;
  logic       cpu_wr_q;
  logic       dma_rd_q;
  logic       dma_wr_q;
  logic       cpu_rd_start;
  logic       cpu_wr_start;
  logic       dma_rd_start;
  logic       dma_wr_start;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] pointer_q;
  logic [7:0] control_one_q;
  logic [7:0] irq_enable_q;
  logic [7:0] device_addr_q;
  logic [6:0] flags_q;
  logic [7:0] role_polarity_q;
  logic [7:0] frame_low_q;
  logic [7:0] frame_high_q;
  logic [15:0] dma_count_q;
  logic       dma_busy;
  logic       dma_done_pulse;
  logic       dma_start;
  logic       dma_byte;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  logic [7:0] status_view;
  logic [7:0] rd_value;
  dma_state_t dma_state_q;

  // either reset source clears the block
  assign reset_all = rst | ~reset_in_n;

  // access qualification: chip select with a strobe, dma uses acknowledge instead
  assign cpu_rd_start = ~chip_select_n & ~read_strobe_n & ~cpu_rd_q;
  assign cpu_wr_start = ~chip_select_n & ~write_strobe_n & ~cpu_wr_q;
  assign dma_rd_start = ~dma_ack_n & ~read_strobe_n & ~dma_rd_q;
  assign dma_wr_start = ~dma_ack_n & ~write_strobe_n & ~dma_wr_q;
  assign reg_wr       = cpu_wr_start & pointer_data_select;
  assign reg_rd       = cpu_rd_start & pointer_data_select;

  // strobe history for edge detection
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      cpu_rd_q <= 1'b0;
      cpu_wr_q <= 1'b0;
      dma_rd_q <= 1'b0;
      dma_wr_q <= 1'b0;
    end else begin
      cpu_rd_q <= ~chip_select_n & ~read_strobe_n;
      cpu_wr_q <= ~chip_select_n & ~write_strobe_n;
      dma_rd_q <= ~dma_ack_n & ~read_strobe_n;
      dma_wr_q <= ~dma_ack_n & ~write_strobe_n;
    end
  end

  // write-only address pointer, loaded with select low
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      pointer_q <= RST_BYTE;
    end else if (cpu_wr_start && !pointer_data_select) begin
      pointer_q <= data_in;
    end
  end

  // control register one: usb enable, dma enable and direction
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      control_one_q <= RST_BYTE;
    end else if (reg_wr && pointer_q == OFS_CONTROL_ONE) begin
      control_one_q <= data_in;
    end
  end

  // interrupt enables, never touching the flags
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      irq_enable_q <= RST_BYTE;
    end else if (reg_wr && pointer_q == OFS_IRQ_ENABLE) begin
      irq_enable_q <= data_in;
    end
  end

  // assigned device address
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      device_addr_q <= RST_ADDR;
    end else if (reg_wr && pointer_q == OFS_DEVICE_ADDR) begin
      device_addr_q <= data_in;
    end
  end

  // role and polarity register, reserved bits kept zero
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      role_polarity_q <= RST_BYTE;
    end else if (reg_wr && pointer_q == OFS_ROLE_POLARITY) begin
      role_polarity_q <= {data_in[CTL2_MASTER], data_in[CTL2_SWAP], 6'h00};
    end
  end

  // frame number capture on every sof; writes are ignored
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      frame_low_q  <= RST_BYTE;
      frame_high_q <= RST_BYTE;
    end else if (usb_evt.sof) begin
      frame_low_q  <= {sof_frame[6:0], 1'b0};
      frame_high_q <= {sof_frame[10:7], 4'h0};
    end
  end

  // sixteen-bit dma count; counts down one per byte moved
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      dma_count_q <= RST_COUNT;
    end else if (reg_wr && pointer_q == OFS_DMA_CNT_LOW) begin
      dma_count_q <= {dma_count_q[15:8], data_in};
    end else if (reg_wr && pointer_q == OFS_DMA_CNT_HIGH) begin
      dma_count_q <= {data_in, dma_count_q[7:0]};
    end else if (dma_byte) begin
      dma_count_q <= dma_count_q - COUNT_ONE;
    end
  end

  // dma start: high count write with dma enabled, role pin one only (role register bit 7 not checked)
  assign dma_start = reg_wr && pointer_q == OFS_DMA_CNT_HIGH &&
                     control_one_q[CTL1_DMA_ENABLE] && role_select;
  assign dma_busy  = dma_state_q != DMA_IDLE;
  assign dma_byte  = dma_state_q == DMA_ACK &&
                     (control_one_q[CTL1_DMA_DIR] ? dma_rd_start : dma_wr_start);
  assign dma_done_pulse = dma_byte && dma_count_q == COUNT_ONE;

  // dma handshake sequencer
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      dma_state_q <= DMA_IDLE;
    end else begin
      case (dma_state_q)
        DMA_IDLE: begin
          if (dma_start && dma_count_q[7:0] != 8'h00) begin
            dma_state_q <= DMA_REQ;
          end else if (dma_start && data_in != 8'h00) begin
            dma_state_q <= DMA_REQ;
          end
        end
        DMA_REQ: begin
          if (!control_one_q[CTL1_DMA_ENABLE]) begin
            dma_state_q <= DMA_IDLE;
          end else if (!dma_ack_n) begin
            dma_state_q <= DMA_ACK;
          end
        end
        DMA_ACK: begin
          if (dma_done_pulse || !control_one_q[CTL1_DMA_ENABLE]) begin
            dma_state_q <= DMA_IDLE;
          end else if (dma_byte) begin
            dma_state_q <= DMA_REQ;
          end
        end
        default: begin
          dma_state_q <= DMA_IDLE;
        end
      endcase
    end
  end

  // request is low while waiting for an acknowledge
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      dma_req_n <= 1'b1;
    end else begin
      dma_req_n <= ~((dma_state_q == DMA_IDLE && dma_start &&
                      {data_in, dma_count_q[7:0]} != RST_COUNT) ||
                     (dma_state_q == DMA_REQ && control_one_q[CTL1_DMA_ENABLE]) ||
                     (dma_state_q == DMA_ACK && dma_byte && !dma_done_pulse &&
                      control_one_q[CTL1_DMA_ENABLE]));
    end
  end

  // endpoint three byte path, reachable only from dma
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      ep3_dma_stb   <= 1'b0;
      ep3_dma_write <= 1'b0;
      ep3_dma_data  <= RST_BYTE;
    end else begin
      ep3_dma_stb   <= dma_byte;
      ep3_dma_write <= ~control_one_q[CTL1_DMA_DIR];
      if (dma_byte && !control_one_q[CTL1_DMA_DIR]) begin
        ep3_dma_data <= data_in;
      end
    end
  end

  // sticky flags: set wins over a same-cycle clear
  assign flag_set = {usb_evt.bus_reset, usb_evt.sof, dma_done_pulse, usb_evt.ep_done};
  assign flag_clr = (reg_wr && pointer_q == OFS_IRQ_FLAGS) ? data_in[6:0] : 7'h00;

  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      flags_q <= 7'h00;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end

  // status view with live dma busy on top
  assign status_view = {dma_busy, flags_q};

  // interrupt from enabled flags only; busy bit excluded
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(flags_q & irq_enable_q[6:0]);
    end
  end

  // read multiplexer
  always_comb begin
    if (pointer_q == OFS_CONTROL_ONE) begin
      rd_value = control_one_q;
    end else if (pointer_q == OFS_IRQ_ENABLE) begin
      rd_value = irq_enable_q;
    end else if (pointer_q == OFS_DEVICE_ADDR) begin
      rd_value = device_addr_q;
    end else if (pointer_q == OFS_IRQ_FLAGS) begin
      rd_value = status_view;
    end else if (pointer_q == OFS_BUFFER_SET) begin
      rd_value = {4'h0, ep_buffer_set};
    end else if (pointer_q == OFS_ROLE_POLARITY) begin
      rd_value = role_polarity_q;
    end else if (pointer_q == OFS_FRAME_LOW) begin
      rd_value = frame_low_q;
    end else if (pointer_q == OFS_FRAME_HIGH) begin
      rd_value = frame_high_q;
    end else if (pointer_q == OFS_DMA_CNT_LOW) begin
      rd_value = dma_count_q[7:0];
    end else if (pointer_q == OFS_DMA_CNT_HIGH) begin
      rd_value = dma_count_q[15:8];
    end else begin
      rd_value = UNMAPPED_VAL;
    end
  end

  // data bus drive: register reads and dma reads from endpoint three
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      data_out  <= RST_BYTE;
      data_oe_n <= 1'b1;
    end else begin
      if (reg_rd) begin
        data_out <= rd_value;
      end else if (dma_state_q == DMA_ACK && control_one_q[CTL1_DMA_DIR] && dma_rd_start) begin
        data_out <= ep3_rd_data;
      end
      data_oe_n <= ~((~chip_select_n & ~read_strobe_n & pointer_data_select) |
                     (dma_state_q == DMA_ACK && control_one_q[CTL1_DMA_DIR] &&
                      ~dma_ack_n && ~read_strobe_n));
    end
  end

  // address filter and mode outputs to the usb engine
  always_ff @(posedge ref_clk) begin
    if (reset_all) begin
      addr_match    <= 1'b0;
      usb_enable    <= 1'b0;
      host_mode     <= 1'b0;
      polarity_swap <= 1'b0;
      pll_enable    <= 1'b0;
    end else begin
      addr_match    <= usb_token.valid && usb_token.addr == device_addr_q[6:0];
      usb_enable    <= control_one_q[CTL1_USB_ENABLE];
      host_mode     <= role_polarity_q[CTL2_MASTER] | ~role_select;
      polarity_swap <= role_polarity_q[CTL2_SWAP];
      pll_enable    <= clock_multiply_sel;
    end
  end

endmodule

// ==== verilog/usb_slave_regs_pkg.sv ====
// constants and types for the usb slave control and status register group
package usb_slave_regs_pkg;

  // register offsets, as seen through the address pointer
  localparam logic [7:0] OFS_CONTROL_ONE   = 8'h05;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h06;
  localparam logic [7:0] OFS_DEVICE_ADDR   = 8'h07;
  localparam logic [7:0] OFS_IRQ_FLAGS     = 8'h0D;
  localparam logic [7:0] OFS_BUFFER_SET    = 8'h0E;
  localparam logic [7:0] OFS_ROLE_POLARITY = 8'h0F;
  localparam logic [7:0] OFS_FRAME_LOW     = 8'h15;
  localparam logic [7:0] OFS_FRAME_HIGH    = 8'h16;
  localparam logic [7:0] OFS_DMA_CNT_LOW   = 8'h35;
  localparam logic [7:0] OFS_DMA_CNT_HIGH  = 8'h36;

  // reset values
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [7:0]  RST_ADDR     = 8'h00;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;
  localparam logic [7:0]  UNMAPPED_VAL = 8'h00;

  // interrupt flag and enable bit positions
  localparam int FLAG_DMA_BUSY  = 7;
  localparam int FLAG_BUS_RESET = 6;
  localparam int FLAG_SOF       = 5;
  localparam int FLAG_DMA_DONE  = 4;
  localparam int NUM_ENDPOINTS  = 4;

  // control register one bit positions
  localparam int CTL1_USB_ENABLE = 0;
  localparam int CTL1_DMA_ENABLE = 1;
  localparam int CTL1_DMA_DIR    = 2;

  // role and polarity register bit positions
  localparam int CTL2_MASTER = 7;
  localparam int CTL2_SWAP   = 6;

  // frame number placement
  localparam int FRAME_BITS = 11;

  // dma handshake states, gray coded along idle, request, acknowledge
  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_REQ  = 2'b01,
    DMA_ACK  = 2'b11
  } dma_state_t;

  // events reported by the usb engine, one-cycle pulses
  typedef struct packed {
    logic                     bus_reset;
    logic                     sof;
    logic [NUM_ENDPOINTS-1:0] ep_done;
  } usb_evt_t;

  // token address seen by the usb engine
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } usb_token_t;

endpackage

// ==== verif/usb_slave_ctrl_status_regs_chk.sv ====
// port-level assertions for the usb slave register group
module usb_slave_ctrl_status_regs_chk (
  // clock and resets
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reset_in_n,
  // pins and processor port
  input wire logic       role_select,
  input wire logic       clock_multiply_sel,
  input wire logic       chip_select_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       pointer_data_select,
  input wire logic [7:0] data_in,
  input wire logic       data_oe_n,
  input wire logic       irq_out,
  // dma handshake and engine side
  input wire logic       dma_req_n,
  input wire logic       dma_ack_n,
  input wire logic       host_mode,
  input wire logic       pll_enable,
  input wire logic       ep3_dma_stb,
  input wire logic       ep3_dma_write,
  input wire logic [7:0] ep3_dma_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // either reset source resets the block
  wire logic rst_any = rst | ~reset_in_n;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst_any);

  // a dma byte handed over in each direction
  sequence s_wr_take;
    !dma_req_n && !dma_ack_n && $fell(write_strobe_n);
  endsequence
  sequence s_rd_take;
    !dma_req_n && !dma_ack_n && $fell(read_strobe_n);
  endsequence

  a_reset_idle: assert property (disable iff (1'b0)
    rst_any |=> dma_req_n && data_oe_n && !irq_out && !ep3_dma_stb)
    else $error("outputs not idle after reset");
  a_pll_follow: assert property (
    !$past(rst_any) |-> pll_enable == $past(clock_multiply_sel))
    else $error("multiplier enable does not follow pin");
  a_host_pin: assert property (
    !$past(rst_any) && !$past(role_select) |-> host_mode)
    else $error("host pin ignored");
  a_req_slave_only: assert property (
    $fell(dma_req_n) |-> $past(role_select))
    else $error("dma request in host role");
  a_dma_wr_byte: assert property (
    s_wr_take |=> ep3_dma_stb && ep3_dma_write && ep3_dma_data == $past(data_in))
    else $error("dma write byte lost");
  a_dma_rd_byte: assert property (
    s_rd_take |=> ep3_dma_stb && !ep3_dma_write)
    else $error("dma read byte lost");
  a_stb_pulse: assert property (
    ep3_dma_stb |=> !ep3_dma_stb)
    else $error("byte strobe longer than one cycle");
  a_oe_read: assert property (
    !chip_select_n && !read_strobe_n && pointer_data_select |=> !data_oe_n)
    else $error("read not driven");
  a_oe_quiet: assert property (
    read_strobe_n |=> data_oe_n)
    else $error("bus driven without read");
endmodule

bind usb_slave_ctrl_status_regs usb_slave_ctrl_status_regs_chk u_chk (
  .ref_clk, .rst, .reset_in_n, .role_select, .clock_multiply_sel, .chip_select_n,
  .read_strobe_n, .write_strobe_n, .pointer_data_select, .data_in, .data_oe_n,
  .irq_out, .dma_req_n, .dma_ack_n, .host_mode, .pll_enable, .ep3_dma_stb,
  .ep3_dma_write, .ep3_dma_data);

// ==== verif/dma_ctrl_model.sv ====
// external dma controller serving the block's request line
module dma_ctrl_model (
  // clock and handshake
  input  wire logic       ref_clk,
  input  wire logic       dma_req_n,
  output logic            dma_ack_n,
  // strobes and data
  output logic            wr_n,
  output logic            rd_n,
  output logic [7:0]      data,
  // direction and answer delay
  input  wire logic       dir_rd,
  input  wire logic [3:0] slow
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle levels at time zero
  initial begin
    dma_ack_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data = 8'hA5;
  end
  // one byte per request: acknowledge first, strobe after
  always begin
    @(negedge ref_clk);
    if (!dma_req_n) begin
      repeat (slow) @(negedge ref_clk);
      dma_ack_n = 1'b0;
      @(negedge ref_clk);
      if (dir_rd) rd_n = 1'b0;
      else wr_n = 1'b0;
      // release once the byte is taken, so a held acknowledge is not seen as the next one
      @(negedge ref_clk);
      dma_ack_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      data = ~data; // released bus shows a changed value
    end
  end
endmodule

// ==== verif/test_usb_slave_ctrl_status_regs.sv ====
// self-checking bench for the usb slave register group
module test_usb_slave_ctrl_status_regs
  import usb_slave_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

  logic        ref_clk = 1'b0, rst = 1'b1, reset_in_n = 1'b1;
  logic        role_select = 1'b1, clock_multiply_sel = 1'b0, dir_rd = 1'b0;
  logic        cs_n = 1'b1, cpu_rd_n = 1'b1, cpu_wr_n = 1'b1, sel = 1'b0;
  logic [7:0]  din = 8'h00, rdata, data_out, m_data;
  logic [3:0]  slow = 4'd0, ep_buffer_set = 4'h0;
  logic [10:0] sof_frame = 11'h000;
  usb_evt_t    usb_evt = '0;
  usb_token_t  usb_token = '0;
  logic        data_oe_n, irq_out, dma_req_n, dma_ack_n, m_wr_n, m_rd_n;
  logic        addr_match, host_mode, polarity_swap, pll_enable, ep3_dma_stb, usb_enable;
  logic [7:0]  ep3_dma_data;
  int          fails = 0, n_checks = 0, n_stb = 0, cycles = 0;

  always #20 ref_clk = ~ref_clk;

  usb_slave_ctrl_status_regs DUT (
    .ref_clk, .rst, .reset_in_n, .role_select, .clock_multiply_sel,
    .chip_select_n(cs_n), .read_strobe_n(cpu_rd_n & m_rd_n),
    .write_strobe_n(cpu_wr_n & m_wr_n), .pointer_data_select(sel),
    .data_in(dma_ack_n ? din : m_data), .data_out, .data_oe_n, .irq_out,
    .dma_req_n, .dma_ack_n, .usb_evt, .usb_token, .sof_frame, .ep_buffer_set,
    .ep3_rd_data(8'h3C), .addr_match, .usb_enable, .host_mode, .polarity_swap,
    .pll_enable, .ep3_dma_stb, .ep3_dma_write(), .ep3_dma_data);

  dma_ctrl_model u_dma (.ref_clk, .dma_req_n, .dma_ack_n, .wr_n(m_wr_n),
    .rd_n(m_rd_n), .data(m_data), .dir_rd, .slow);

  // byte count and run ceiling, well above the ~1000 cycles needed
  always @(posedge ref_clk) begin
    if (ep3_dma_stb === 1'b1) n_stb++;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  // verdict and end of run
  task automatic end_sim();
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one processor bus cycle, strobe high for a cycle after
  task automatic cyc(input logic a0, input logic [7:0] d, input logic rd);
    sel = a0;
    din = d;
    cs_n = 1'b0;
    if (rd) cpu_rd_n = 1'b0;
    else cpu_wr_n = 1'b0;
    @(negedge ref_clk);
    rdata = data_out;
    cs_n = 1'b1;
    cpu_rd_n = 1'b1;
    cpu_wr_n = 1'b1;
    din = ~d;
    @(negedge ref_clk);
  endtask

  // pointer then data write, then let outputs settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b0, a, 1'b0);
    cyc(1'b1, d, 1'b0);
    repeat (2) @(negedge ref_clk);
  endtask

  // pointer write then data read, compared
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    cyc(1'b0, a, 1'b0);
    cyc(1'b1, 8'h00, 1'b1);
    `CHK(rdata, e)
  endtask

  // idle outputs, address reset by both reset inputs
  task automatic t_reset();
    `CHK({irq_out, dma_req_n, data_oe_n}, 3'b011)
    chk_rd(OFS_DEVICE_ADDR, RST_ADDR);
    wr(OFS_DEVICE_ADDR, 8'h33);
    reset_in_n = 1'b0;
    @(negedge ref_clk);
    reset_in_n = 1'b1;
    chk_rd(OFS_DEVICE_ADDR, RST_ADDR);
  endtask

  // role and polarity bits, pins, read-only and unmapped places
  task automatic t_regs();
    wr(OFS_ROLE_POLARITY, 8'hFF);
    chk_rd(OFS_ROLE_POLARITY, 8'hC0);
    `CHK({host_mode, polarity_swap}, 2'b11)
    wr(OFS_ROLE_POLARITY, 8'h00);
    `CHK({host_mode, polarity_swap}, 2'b00)
    role_select = 1'b0;
    clock_multiply_sel = 1'b1;
    @(negedge ref_clk);
    `CHK({host_mode, pll_enable}, 2'b11)
    role_select = 1'b1;
    clock_multiply_sel = 1'b0;
    @(negedge ref_clk);
    `CHK({host_mode, pll_enable}, 2'b00)
    ep_buffer_set = 4'hA;
    wr(OFS_BUFFER_SET, 8'hFF);
    chk_rd(OFS_BUFFER_SET, 8'h0A);
    chk_rd(8'h40, UNMAPPED_VAL);
  endtask

  // token address match against the held address
  task automatic t_addr();
    wr(OFS_DEVICE_ADDR, 8'h5A);
    chk_rd(OFS_DEVICE_ADDR, 8'h5A);
    usb_token = '{1'b1, 7'h5A};
    @(negedge ref_clk);
    `CHK(addr_match, 1'b1)
    usb_token = '{1'b1, 7'h5B};
    @(negedge ref_clk);
    `CHK(addr_match, 1'b0)
    usb_token = '0;
  endtask

  // event flags, frame number, enables and clearing
  task automatic t_flags();
    wr(OFS_IRQ_ENABLE, 8'h7F);
    sof_frame = 11'h5A3;
    usb_evt = '{1'b1, 1'b1, 4'hF};
    @(negedge ref_clk);
    usb_evt = '0;
    sof_frame = 11'h000;
    chk_rd(OFS_IRQ_FLAGS, 8'h6F);
    `CHK(irq_out, 1'b1)
    chk_rd(OFS_FRAME_LOW, 8'h46);
    chk_rd(OFS_FRAME_HIGH, 8'hB0);
    `CHK(rdata & 8'hF0, 8'hB0)
    wr(OFS_IRQ_FLAGS, 8'h05);
    chk_rd(OFS_IRQ_FLAGS, 8'h6A);
    wr(OFS_IRQ_ENABLE, 8'h00);
    `CHK(irq_out, 1'b0)
    chk_rd(OFS_IRQ_FLAGS, 8'h6A);
    wr(OFS_IRQ_ENABLE, 8'h20);
    `CHK(irq_out, 1'b1)
    wr(OFS_IRQ_FLAGS, 8'hFF);
    chk_rd(OFS_IRQ_FLAGS, 8'h00);
    `CHK(irq_out, 1'b0)
  endtask

  // refused starts, a 258-byte write run, a slow one-byte read run
  task automatic t_dma();
    wr(OFS_CONTROL_ONE, 8'h00);
    wr(OFS_DMA_CNT_LOW, 8'h01);
    wr(OFS_DMA_CNT_HIGH, 8'h00);
    `CHK(dma_req_n, 1'b1)
    wr(OFS_IRQ_ENABLE, 8'h80);
    wr(OFS_CONTROL_ONE, 8'h02);
    `CHK(usb_enable, 1'b0)
    n_stb = 0;
    wr(OFS_DMA_CNT_LOW, 8'h02);
    wr(OFS_DMA_CNT_HIGH, 8'h01);
    for (int i = 0; i < 3000 && n_stb < 258; i++) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    `CHK(n_stb, 258)
    chk_rd(OFS_IRQ_FLAGS, 8'h10);
    wr(OFS_IRQ_FLAGS, 8'hFF);
    wr(OFS_CONTROL_ONE, 8'h07);
    `CHK(usb_enable, 1'b1)
    dir_rd = 1'b1;
    slow = 4'd15;
    n_stb = 0;
    wr(OFS_DMA_CNT_LOW, 8'h01);
    wr(OFS_DMA_CNT_HIGH, 8'h00);
    chk_rd(OFS_IRQ_FLAGS, 8'h80);
    `CHK(irq_out, 1'b0)
    for (int i = 0; i < 100 && n_stb < 1; i++) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    `CHK(data_out, 8'h3C)
    chk_rd(OFS_IRQ_FLAGS, 8'h10);
    wr(OFS_IRQ_ENABLE, 8'h10);
    `CHK(irq_out, 1'b1)
    role_select = 1'b0;
    wr(OFS_DMA_CNT_LOW, 8'h01);
    wr(OFS_DMA_CNT_HIGH, 8'h00);
    `CHK(dma_req_n, 1'b1)
    role_select = 1'b1;
  endtask

  // reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_reset();
    t_regs();
    t_addr();
    t_flags();
    t_dma();
    end_sim();
  end
endmodule
